// >>> qsg_pkg.sv
// Constants and types for the questionable status group register bank.
// Assumes an APB master with 32-bit data and byte addresses.
package qsg_pkg;

  // ==========================================================================
  // Group layout
  // ==========================================================================
  // Group 0 is the instrument group, groups 1..3 are the phase summaries
  localparam int QSG_GROUPS = 4;
  localparam int QSG_DATA_W = 32;
  localparam int QSG_STRB_W = 4;
  localparam int QSG_LANE_W = 8;

  // ==========================================================================
  // Address fields
  // ==========================================================================
  localparam int QSG_GLOBAL_BIT = 7;
  localparam int QSG_GRP_MSB = 6;
  localparam int QSG_GRP_LSB = 5;
  localparam int QSG_OFF_MSB = 4;
  localparam int QSG_DEC_MSB = 7;
  localparam logic [31:0] QSG_ADDR_HI_MASK = 32'hFFFF_FF03;

  // ==========================================================================
  // Per-group offsets within a group window
  // ==========================================================================
  localparam logic [4:0] QSG_OFF_COND = 5'h00;
  localparam logic [4:0] QSG_OFF_EVENT = 5'h04;
  localparam logic [4:0] QSG_OFF_ENABLE = 5'h08;
  localparam logic [4:0] QSG_OFF_FALL = 5'h0C;
  localparam logic [4:0] QSG_OFF_RISE = 5'h10;

  // ==========================================================================
  // Global registers
  // ==========================================================================
  localparam logic [7:0] QSG_ADDR_CMD = 8'h80;
  localparam logic [7:0] QSG_ADDR_IRQ_STATUS = 8'h84;
  localparam logic [7:0] QSG_ADDR_IRQ_CLEAR = 8'h88;
  localparam logic [7:0] QSG_ADDR_IRQ_ENABLE = 8'h8C;
  localparam logic [7:0] QSG_ADDR_SUMMARY = 8'h90;

  // Summary register: bit 0 summary, bits 4..7 per-group hits
  localparam int QSG_SUM_QUESTIONABLE_SUMMARY_BIT_BIT = 0;
  localparam int QSG_SUM_HIT_LSB = 4;

  // ==========================================================================
  // Commands and reset values
  // ==========================================================================
  typedef struct packed {
    logic reset;
    logic clear_status;
    logic preset;
  } qsg_cmd_t;

  localparam int QSG_CMD_W = 3;
  localparam logic [31:0] QSG_RDATA_RST = 32'h0000_0000;
  localparam logic [QSG_GROUPS-1:0] QSG_IRQ_RST = 4'h0;

endpackage

// >>> qsg_questionable_status_group.sv
// Register bank of the questionable status group and its three phase groups.
// Assumes an APB master on pclk; condition inputs synchronous to pclk.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module qsg_questionable_status_group
  import qsg_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [QSG_DATA_W-1:0] pwdata,
  input wire logic [QSG_STRB_W-1:0] pstrb,
  input wire logic [QSG_GROUPS-1:0][WIDTH-1:0] cond_in,
  output logic [QSG_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic questionable_summary_bit,
  output logic irq,
  output logic instr_reset
);

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  generate
    if (WIDTH < 1 || WIDTH > QSG_DATA_W) begin : g_bad_width
      $error("WIDTH must lie between 1 and 32");
    end
  endgenerate

  // ==========================================================================
  // State
  // ==========================================================================
  logic [WIDTH-1:0] enable_reg [QSG_GROUPS];
  logic [WIDTH-1:0] falling_edge_filter_reg [QSG_GROUPS];
  logic [WIDTH-1:0] rising_edge_filter_reg [QSG_GROUPS];
  logic [WIDTH-1:0] event_reg [QSG_GROUPS];
  logic [WIDTH-1:0] event_next [QSG_GROUPS];
  logic [WIDTH-1:0] cond_prev_reg [QSG_GROUPS];
  logic [WIDTH-1:0] event_set [QSG_GROUPS];
  logic [QSG_GROUPS-1:0] group_hit;
  logic [QSG_GROUPS-1:0] group_new;
  logic [QSG_GROUPS-1:0] irq_status_reg;
  logic [QSG_GROUPS-1:0] irq_status_next;
  logic [QSG_GROUPS-1:0] irq_enable_reg;
  logic [QSG_DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic questionable_summary_bit_reg;
  logic irq_reg;
  logic instr_reset_reg;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  logic setup_done;
  logic complete;
  logic addr_ok;
  logic is_global;
  logic [1:0] grp_sel;
  logic [4:0] grp_off;
  logic mapped;
  logic read_only;
  logic [QSG_DATA_W-1:0] rd_val;
  logic [QSG_DATA_W-1:0] lane_mask;
  logic wr_en;
  logic rd_en;
  logic [QSG_DATA_W-1:0] wdata_lanes;
  qsg_cmd_t cmd;

  // First access cycle samples, second one completes
  assign setup_done = psel & penable & ~pready_reg;
  assign complete = psel & penable & pready_reg;
  assign addr_ok = (paddr & QSG_ADDR_HI_MASK) == '0;
  assign is_global = paddr[QSG_GLOBAL_BIT];
  assign grp_sel = paddr[QSG_GRP_MSB:QSG_GRP_LSB];
  assign grp_off = paddr[QSG_OFF_MSB:0];

  // Byte enables widen into a bit mask
  genvar ln;
  generate
    for (ln = 0; ln < QSG_STRB_W; ln++) begin : g_lane
      assign lane_mask[ln*QSG_LANE_W +: QSG_LANE_W] = {QSG_LANE_W{pstrb[ln]}};
    end
  endgenerate

  always_comb begin
    rd_val = '0;
    mapped = 1'b0;
    read_only = 1'b0;
    if (addr_ok && !is_global) begin
      case (grp_off)
        QSG_OFF_COND: begin
          rd_val = QSG_DATA_W'(cond_in[grp_sel]);
          mapped = 1'b1;
          read_only = 1'b1;
        end
        QSG_OFF_EVENT: begin
          rd_val = QSG_DATA_W'(event_reg[grp_sel]);
          mapped = 1'b1;
          read_only = 1'b1;
        end
        QSG_OFF_ENABLE: begin
          rd_val = QSG_DATA_W'(enable_reg[grp_sel]);
          mapped = 1'b1;
        end
        QSG_OFF_FALL: begin
          rd_val = QSG_DATA_W'(falling_edge_filter_reg[grp_sel]);
          mapped = 1'b1;
        end
        QSG_OFF_RISE: begin
          rd_val = QSG_DATA_W'(rising_edge_filter_reg[grp_sel]);
          mapped = 1'b1;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end else if (addr_ok) begin
      case (paddr[QSG_DEC_MSB:0])
        // Write-only registers read as zero
        QSG_ADDR_CMD: begin
          mapped = 1'b1;
        end
        QSG_ADDR_IRQ_CLEAR: begin
          mapped = 1'b1;
        end
        QSG_ADDR_IRQ_STATUS: begin
          rd_val = QSG_DATA_W'(irq_status_reg);
          mapped = 1'b1;
          read_only = 1'b1;
        end
        QSG_ADDR_IRQ_ENABLE: begin
          rd_val = QSG_DATA_W'(irq_enable_reg);
          mapped = 1'b1;
        end
        QSG_ADDR_SUMMARY: begin
          rd_val[QSG_SUM_QUESTIONABLE_SUMMARY_BIT_BIT] = questionable_summary_bit_reg;
          rd_val[QSG_SUM_HIT_LSB +: QSG_GROUPS] = group_hit;
          mapped = 1'b1;
          read_only = 1'b1;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
  end

  // Side effects happen only at the completing edge
  assign wr_en = complete & pwrite & mapped & ~read_only;
  assign rd_en = complete & ~pwrite & mapped;
  assign wdata_lanes = pwdata & lane_mask;

  // Commands are self-clearing strobes
  always_comb begin
    cmd = '0;
    if (wr_en && is_global && paddr[QSG_DEC_MSB:0] == QSG_ADDR_CMD) begin
      cmd = qsg_cmd_t'(wdata_lanes[QSG_CMD_W-1:0]);
    end
  end

  // ==========================================================================
  // APB answer
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_done;
    end
  end

  // Read data latched at the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= QSG_RDATA_RST;
    end else if (setup_done) begin
      prdata_reg <= pwrite ? QSG_RDATA_RST : rd_val;
    end
  end

  // Unmapped address or write to a read-only register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= setup_done & ~(mapped & ~(pwrite & read_only));
    end
  end

  // ==========================================================================
  // Status groups
  // ==========================================================================
  // One instrument group plus three phase groups
  genvar g;
  generate
    for (g = 0; g < QSG_GROUPS; g++) begin : g_group
      logic grp_wr;
      logic ev_read;
      logic [WIDTH-1:0] ev_clear;
      logic [WIDTH-1:0] wr_bits;
      logic [WIDTH-1:0] wr_keep;

      assign grp_wr = wr_en & ~is_global & (grp_sel == 2'(g));
      assign ev_read = rd_en & ~is_global & (grp_sel == 2'(g)) & (grp_off == QSG_OFF_EVENT);
      // Bit n of the write is bit n of the mask
      assign wr_bits = wdata_lanes[WIDTH-1:0];
      assign wr_keep = ~lane_mask[WIDTH-1:0];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          enable_reg[g] <= '0;
        end else if (cmd.preset) begin
          enable_reg[g] <= '0;
        end else if (grp_wr && grp_off == QSG_OFF_ENABLE) begin
          enable_reg[g] <= (enable_reg[g] & wr_keep) | wr_bits;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          falling_edge_filter_reg[g] <= '0;
        end else if (cmd.preset) begin
          falling_edge_filter_reg[g] <= '0;
        end else if (grp_wr && grp_off == QSG_OFF_FALL) begin
          falling_edge_filter_reg[g] <= (falling_edge_filter_reg[g] & wr_keep) | wr_bits;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rising_edge_filter_reg[g] <= '0;
        end else if (cmd.preset) begin
          rising_edge_filter_reg[g] <= '1;
        end else if (grp_wr && grp_off == QSG_OFF_RISE) begin
          rising_edge_filter_reg[g] <= (rising_edge_filter_reg[g] & wr_keep) | wr_bits;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cond_prev_reg[g] <= '0;
        end else begin
          cond_prev_reg[g] <= cond_in[g];
        end
      end

      assign event_set[g] = (cond_in[g] & ~cond_prev_reg[g] & rising_edge_filter_reg[g])
                          | (~cond_in[g] & cond_prev_reg[g] & falling_edge_filter_reg[g]);

      // A read clears only the bits it returned; clear_status clears every bit
      assign ev_clear = ({WIDTH{ev_read}} & prdata_reg[WIDTH-1:0]) | {WIDTH{cmd.clear_status}};

      // Sticky, new events beat a clear
      assign event_next[g] = (event_reg[g] & ~ev_clear) | event_set[g];

      // Instrument reset does not touch events
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          event_reg[g] <= '0;
        end else begin
          event_reg[g] <= event_next[g];
        end
      end

      assign group_hit[g] = |(event_reg[g] & enable_reg[g]);
      assign group_new[g] = |event_set[g];
    end
  endgenerate

  // ==========================================================================
  // Summary and command outputs
  // ==========================================================================
  // Summary bit follows masked events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      questionable_summary_bit_reg <= 1'b0;
    end else begin
      questionable_summary_bit_reg <= |group_hit;
    end
  end

  // Pulse toward the rest of the instrument
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reset_reg <= 1'b0;
    end else begin
      instr_reset_reg <= cmd.reset;
    end
  end

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  // New event of a group sets its bit; set wins over write-one-to-clear
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_en && is_global && paddr[QSG_DEC_MSB:0] == QSG_ADDR_IRQ_CLEAR) begin
      irq_status_next = irq_status_reg & ~wdata_lanes[QSG_GROUPS-1:0];
    end
    irq_status_next = irq_status_next | group_new;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= QSG_IRQ_RST;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg <= QSG_IRQ_RST;
    end else if (wr_en && is_global && paddr[QSG_DEC_MSB:0] == QSG_ADDR_IRQ_ENABLE) begin
      irq_enable_reg <= wdata_lanes[QSG_GROUPS-1:0];
    end
  end

  // Registered from the next status value, so in step with the status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_next & irq_enable_reg);
    end
  end

  // ==========================================================================
  // Output drive
  // ==========================================================================
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign questionable_summary_bit = questionable_summary_bit_reg;
  assign irq = irq_reg;
  assign instr_reset = instr_reset_reg;

endmodule // qsg_questionable_status_group

// >>> qsg_properties.sv
// Port checker for the questionable status group.
// Assumes binding to the top module, single pclk domain.
`timescale 1ns/1ps

module qsg_properties
  import qsg_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [QSG_DATA_W-1:0] pwdata,
  input wire logic [QSG_STRB_W-1:0] pstrb,
  input wire logic [QSG_GROUPS-1:0][WIDTH-1:0] cond_in,
  input wire logic [QSG_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic questionable_summary_bit,
  input wire logic irq,
  input wire logic instr_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic cmd_done;
  assign acc = psel & penable & pready;
  assign cmd_done = acc & pwrite & pstrb[0] & (paddr == 32'h0000_0080);
  // ==========================================================
  // Bus timing
  // ==========================================================
  ready_wait_a: assert property ($rose(psel & penable) |-> !pready ##1 pready) else $error("late ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  // ==========================================================
  // Registers and commands
  // ==========================================================
  cond_live_a: assert property (
    (psel & penable & !pready & !pwrite & paddr == 32'h0000_0020) |=> prdata[WIDTH-1:0] == $past(cond_in[1]))
    else $error("stale condition");
  ro_event_a: assert property (acc & pwrite & paddr == 32'h0000_0024 |-> pslverr) else $error("event writable");
  ro_cond_a: assert property (acc & pwrite & paddr == 32'h0000_0000 |-> pslverr) else $error("cond writable");
  // Stable inputs, else a same-cycle event may win
  clear_sum_a: assert property (cmd_done & pwdata[1] & $stable(cond_in) |=> ##1 !questionable_summary_bit)
    else $error("summary after clear");
  preset_sum_a: assert property (cmd_done & pwdata[0] |=> ##1 !questionable_summary_bit) else $error("mask kept");
  reset_pulse_a: assert property (cmd_done & pwdata[2] |=> instr_reset ##1 !instr_reset)
    else $error("bad reset pulse");
  cover property (cmd_done & pwdata[0]);
  cover property (irq);
  cover property (acc & !pwrite & paddr[4:0] == 5'h04 & prdata != 32'h0000_0000);
endmodule // qsg_properties

bind qsg_questionable_status_group qsg_properties #(.WIDTH(WIDTH)) chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .cond_in(cond_in), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .questionable_summary_bit(questionable_summary_bit), .irq(irq), .instr_reset(instr_reset));

// >>> questionable_status_group_tb.sv
// Self-checking bench for the questionable status group.
// Assumes the checker file binds itself to the design.
`timescale 1ns/1ps

module questionable_status_group_tb;
  import qsg_pkg::*;
  localparam int W = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [QSG_GROUPS-1:0][W-1:0] cond = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic qsb;
  logic irq;
  logic instr_reset;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  always #12.5 pclk = ~pclk;

  qsg_questionable_status_group #(.WIDTH(W)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .cond_in(cond),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .questionable_summary_bit(qsb), .irq(irq),
    .instr_reset(instr_reset));

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Single-bit results: error flag, summary bit, interrupt
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Waits on pready with no assumed latency
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] ad(input int g, input int o);
    return 32'(g * 32 + o);
  endfunction

  function automatic logic [W-1:0] edges(input logic [W-1:0] p, c, r, f);
    return (~p & c & r) | (p & ~c & f);
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    int g;
    logic [W-1:0] r, f, en, a, b, ex;
    logic [3:0] ie;
    logic hit;
    void'($urandom(32'h0000_2DCA));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (g = 0; g < 4; g++) begin
      for (int o = 8; o <= 16; o += 4) begin
        apb(1'b0, ad(g, o), 32'h0000_0000);
        chk(rd, 32'h0000_0000);
      end
    end
    apb(1'b0, 32'h0000_0014, 32'h0000_0000);
    chk_bit(err, 1'b1);
    apb(1'b1, ad(1, 4), 32'h0000_FFFF);
    chk_bit(err, 1'b1);
    apb(1'b1, ad(0, 0), 32'h0000_FFFF);
    chk_bit(err, 1'b1);
    for (int i = 0; i < 12; i++) begin
      g = (i < 4) ? i : $urandom_range(3);
      r = W'($urandom);
      f = W'($urandom);
      en = W'($urandom);
      ie = 4'($urandom);
      a = W'($urandom);
      b = (i == 3) ? ~a : W'($urandom);
      if (i == 1) begin
        r = '1;
        f = '1;
      end
      if (i == 2) begin
        r = '0;
        f = '0;
      end
      apb(1'b1, 32'h0000_0080, 32'h0000_0003);
      apb(1'b1, 32'h0000_0088, 32'h0000_000F);
      apb(1'b0, ad(g, 16), 32'h0000_0000);
      chk(rd, 32'h0000_FFFF);
      apb(1'b0, ad(g, 12), 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, ad(g, 8), 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b1, ad(g, 8), 32'(en));
      apb(1'b1, ad(g, 12), 32'(f));
      apb(1'b1, ad(g, 16), 32'(r));
      apb(1'b1, 32'h0000_008C, 32'(ie));
      apb(1'b0, ad(g, 16), 32'h0000_0000);
      chk(rd, 32'(r));
      ex = edges(cond[g], a, r, f) | edges(a, b, r, f);
      hit = |(ex & en);
      @(posedge pclk);
      cond[g] <= a;
      @(posedge pclk);
      cond[g] <= b;
      repeat (3) @(posedge pclk);
      chk_bit(qsb, hit);
      chk_bit(irq, (ex != '0) & ie[g]);
      apb(1'b0, 32'h0000_0090, 32'h0000_0000);
      chk(rd, (32'(hit) << (QSG_SUM_HIT_LSB + g)) | 32'(hit));
      apb(1'b0, 32'h0000_0084, 32'h0000_0000);
      chk(rd, 32'({3'b000, ex != '0} << g));
      apb(1'b1, 32'h0000_0080, 32'h0000_0004);
      apb(1'b0, ad(g, 4), 32'h0000_0000);
      chk(rd, 32'(ex));
      apb(1'b0, ad(g, 4), 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, ad(g, 0), 32'h0000_0000);
      chk(rd, 32'(b));
      apb(1'b1, 32'h0000_0088, 32'h0000_000F);
      repeat (2) @(posedge pclk);
      chk_bit(qsb, 1'b0);
      chk_bit(irq, 1'b0);
    end
    apb(1'b1, ad(3, 8), 32'h0000_00A5);
    apb(1'b1, 32'h0000_0080, 32'h0000_0002);
    apb(1'b0, ad(3, 8), 32'h0000_0000);
    chk(rd, 32'h0000_00A5);
    end_of_test();
  end
endmodule // questionable_status_group_tb
